// File: design/serial_shifter.sv
/*
 * Serial input shift register on the host's serial clock.
 * Assumes the host owns sclk and data; sclk may stop between words.
 */
`timescale 1ns/10ps
module serial_shifter #(
   parameter int W = 18
) (
   // Link clock domain
   input  wire logic         sclk,
   input  wire logic         rst,
   // Serial data and parallel view
   input  wire logic         sdata,
   output logic      [W-1:0] word
);
   // Msb enters first, so the last bit lands in bit 0
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         word <= '0;
      end else begin
         word <= {word[W-2:0], sdata}; // R01 R02
      end
   end

   property p_shift_in;
      @(posedge sclk) disable iff (rst)
      !$past(rst) |-> word == {$past(word[W-2:0]), $past(sdata)};
   endproperty
   a_shift_in: assert property (p_shift_in) // R01
      else $error("shift register did not take data on sclk");
endmodule

// File: design/sync2.sv
/*
 * Two flip-flop synchroniser for a group of quasi-static bits.
 * Assumes each bit is stable long enough to be caught, or is a level.
 */
`timescale 1ns/10ps
module sync2 #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clocking
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else if (ce) begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// File: design/synth_serial_load_control.sv
/*
 * Serial load and control logic of an RF frequency synthesizer: serial
 * word capture, latch load, phase sense, bypass switch, sleep gating,
 * lock indicator, comparator monitor, prescaler ratio and a classic
 * Wishbone register slave. Assumes ref_div_in and var_div_in come from
 * counter logic on clk; sclk, sdata and the strobe/control pins come
 * from the host asynchronously.
 */
// The address map and the Wishbone register port were decided locally.
// Operation
// R01 - Each rising serial clock edge shifts the data pin into the word.
// R02 - Words arrive msb first and the last bit is the latch select.
// R03 - A rising load strobe moves the word into the selected latch.
// R04 - The host keeps the serial clock low while the strobe moves.
// R05 - A low phase sense input swaps the pump up and down response.
// R06 - A high load strobe routes the pump onto the bypass output.
// R07 - A high sleep request pin runs normally, low asks for sleep.
// R08 - Power-down waits until the pump has gone high impedance.
// R09 - The lock output stays high with narrow lows while locked.
// R10 - The prescaler offers 64 or 128, or 32 or 64 in fast parts.
// R11 - The monitor output shows the selected comparator input.
// R12 - Word width and latch selection are parameters.
`timescale 1ns/10ps
module synth_serial_load_control #(
   parameter int   WORD_W        = synth_pkg::WORD_W_DEF,
   parameter int   CTRL_W        = synth_pkg::CTRL_W_DEF,
   parameter int   ADR_W         = synth_pkg::ADR_W_DEF,
   parameter logic HIGH_VARIANT  = 1'b0
) (
   // System clock
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   // Serial link from the host
   input  wire logic                      sclk,
   input  wire logic                      sdata,
   input  wire logic                      load_strobe,
   // Control pins
   input  wire logic                      phase_sense_select,
   input  wire logic                      sleep_request_n,
   // Phase comparator inputs
   input  wire logic                      ref_div_in,
   input  wire logic                      var_div_in,
   // Pump, switch and monitor outputs
   output logic                           pump_out,
   output logic                           pump_oe,
   output logic                           bypass_switch_out,
   output logic                           bypass_switch_oe,
   output logic                           lock_indicator,
   output logic                           compare_monitor_out,
   output logic                           power_down,
   output logic [7:0]                     prescaler_modulus,
   // Loaded latches, latch i at bits i*WORD_W
   output logic [(2**CTRL_W)*WORD_W-1:0]  latch_data,
   output logic                           load_pulse,
   // Wishbone slave
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [ADR_W-1:0]          wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o
);
   import synth_pkg::*;

   localparam int NUM_LATCH = 2**CTRL_W;

   // ------------------------------------------------------------------
   // Serial capture on the link clock
   // ------------------------------------------------------------------
   logic [WORD_W-1:0] shift_word;
   logic [WORD_W-1:0] word_sync;
   logic [2:0]        pin_sync;

   serial_shifter #(
      .W     (WORD_W)
   ) u_shift (
      .sclk  (sclk),
      .rst   (rst),
      .sdata (sdata),
      .word  (shift_word)
   );

   // The word is quiet once the host parks sclk low around the strobe,
   // so two stages are enough and line up with the strobe's own two
   sync2 #(
      .W       (WORD_W),
      .RST_VAL ('0)
   ) u_word_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   (shift_word), // R04
      .q   (word_sync)
   );

   sync2 #(
      .W       (3),
      .RST_VAL (PIN_RESET)
   ) u_pin_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   ({load_strobe, phase_sense_select, sleep_request_n}),
      .q   (pin_sync)
   );

   // Synchronised pin levels
   wire strobe_lvl = pin_sync[2];
   wire sense_lvl  = pin_sync[1];
   wire wake_lvl   = pin_sync[0];

   // ------------------------------------------------------------------
   // Latch load
   // ------------------------------------------------------------------
   logic                strobe_prev;
   logic [WORD_W-1:0]   latch_mem [NUM_LATCH];
   logic [CTRL_W-1:0]   last_sel;
   logic [15:0]         load_count;

   // Low bits of the word pick the destination latch
   wire                load_rise = strobe_lvl & ~strobe_prev;
   wire [CTRL_W-1:0]   word_sel  = word_sync[CTRL_W-1:0]; // R02 R12

   // Latch update on the strobe's rising edge only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_prev <= PIN_RESET[2];
         last_sel    <= '0;
         load_count  <= LOADCNT_RESET;
         load_pulse  <= 1'b0;
         for (int i = 0; i < NUM_LATCH; i++) begin
            latch_mem[i] <= '0;
         end
      end else if (ce) begin
         strobe_prev <= strobe_lvl;
         load_pulse  <= load_rise;
         if (load_rise) begin
            latch_mem[word_sel] <= word_sync; // R03
            last_sel            <= word_sel;
            load_count          <= load_count + 16'h0001;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_LATCH; g++) begin : g_latch_out
         assign latch_data[g*WORD_W +: WORD_W] = latch_mem[g];
      end
   endgenerate

   // ------------------------------------------------------------------
   // Phase comparator and pump
   // ------------------------------------------------------------------
   power_state_t pwr_state;
   power_state_t next_pwr_state;
   logic         ref_prev;
   logic         var_prev;
   logic         raw_up;
   logic         raw_dn;
   logic         pump_up;
   logic         pump_dn;

   // Edge-triggered detector; both set means both reset
   wire ref_rise   = ref_div_in & ~ref_prev;
   wire var_rise   = var_div_in & ~var_prev;
   wire up_set     = raw_up | ref_rise;
   wire dn_set     = raw_dn | var_rise;
   wire both_set   = up_set & dn_set;
   wire pfd_hold   = (pwr_state == PWR_SLEEP);
   wire next_up    = up_set & ~both_set & ~pfd_hold;
   wire next_dn    = dn_set & ~both_set & ~pfd_hold;

   // Swapping here turns the whole comparator-pump response around
   wire swap       = ~sense_lvl;
   wire next_pu    = swap ? raw_dn : raw_up; // R05
   wire next_pd    = swap ? raw_up : raw_dn; // R05

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_prev <= 1'b0;
         var_prev <= 1'b0;
         raw_up   <= 1'b0;
         raw_dn   <= 1'b0;
         pump_up  <= 1'b0;
         pump_dn  <= 1'b0;
      end else if (ce) begin
         ref_prev <= ref_div_in;
         var_prev <= var_div_in;
         raw_up   <= next_up;
         raw_dn   <= next_dn;
         pump_up  <= next_pu & ~pfd_hold;
         pump_dn  <= next_pd & ~pfd_hold;
      end
   end

   // Pump drives high to source, low to sink, floats when idle
   assign pump_out = pump_up;
   assign pump_oe  = pump_up | pump_dn;

   // Switch only closes while the strobe is high
   assign bypass_switch_out = pump_out;                // R06
   assign bypass_switch_oe  = strobe_lvl & pump_oe;    // R06

   // ------------------------------------------------------------------
   // Power state
   // ------------------------------------------------------------------
   // Sleep only once no pulse is out or pending, so the VCO never jumps
   wire pump_idle = ~pump_oe & ~raw_up & ~raw_dn;

   always_comb begin
      next_pwr_state = pwr_state;
      case (pwr_state)
         PWR_RUN: begin
            if (!wake_lvl) begin
               next_pwr_state = PWR_DRAIN; // R07
            end
         end
         PWR_DRAIN: begin
            if (wake_lvl) begin
               next_pwr_state = PWR_RUN;
            end else if (pump_idle) begin
               next_pwr_state = PWR_SLEEP; // R08
            end
         end
         PWR_SLEEP: begin
            if (wake_lvl) begin
               next_pwr_state = PWR_RUN; // R07
            end
         end
         default: begin
            next_pwr_state = PWR_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_state <= PWR_RUN;
      end else if (ce) begin
         pwr_state <= next_pwr_state;
      end
   end

   assign power_down = (pwr_state == PWR_SLEEP);

   // ------------------------------------------------------------------
   // Lock indicator, monitor and prescaler
   // ------------------------------------------------------------------
   logic [1:0] ctrl;

   // Narrow pump pulses in lock show as narrow lows
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_indicator      <= 1'b0;
         compare_monitor_out <= 1'b0;
      end else if (ce) begin
         lock_indicator      <= ~pump_oe & ~power_down;  // R09
         compare_monitor_out <= ctrl[CTRL_MON_SEL] ?
                                var_div_in : ref_div_in; // R11
      end
   end

   // Ratio pair depends on the frequency grade of the part
   wire [7:0] ratio_lo = HIGH_VARIANT ? PRESC_32 : PRESC_64;
   wire [7:0] ratio_hi = HIGH_VARIANT ? PRESC_64 : PRESC_128;
   assign prescaler_modulus = ctrl[CTRL_PRESC_HI] ?
                              ratio_hi : ratio_lo;       // R10

   // ------------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------------
   wire [ADR_W-3:0] word_idx  = wb_adr_i[ADR_W-1:2];
   wire [ADR_W-3:0] latch_rel = word_idx - OFF_LATCH0[ADR_W-1:2];
   wire             req       = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce;
   wire             hit_ctrl  = (wb_adr_i == OFF_CTRL[ADR_W-1:0]);
   wire             hit_stat  = (wb_adr_i == OFF_STATUS[ADR_W-1:0]);
   wire             hit_cnt   = (wb_adr_i == OFF_LOADCNT[ADR_W-1:0]);
   wire             hit_latch = (wb_adr_i[1:0] == 2'h0) &&
                                (latch_rel < (ADR_W-2)'(NUM_LATCH));
   wire             wr_ctrl   = req & wb_we_i & hit_ctrl & wb_sel_i[0];

   wire [7:0]  ratio_word  = prescaler_modulus;
   wire [31:0] status_word = {16'h0000, ratio_word, 2'h0,
                              (pwr_state == PWR_DRAIN), pump_oe,
                              strobe_lvl, sense_lvl, power_down,
                              lock_indicator};

   // Unmapped addresses read as zero and still acknowledge
   wire [31:0] rd_word =
      hit_ctrl  ? {30'h0, ctrl} :
      hit_stat  ? status_word :
      hit_cnt   ? {16'h0000, load_count} :
      hit_latch ? {{(32-WORD_W){1'b0}},
                   latch_mem[latch_rel[CTRL_W-1:0]]} :
                  32'h00000000;

   // One wait state: ack follows the request by one edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl     <= CTRL_RESET;
      end else if (ce) begin
         wb_ack_o <= req;
         if (req) begin
            wb_dat_o <= rd_word;
         end
         if (wr_ctrl) begin
            ctrl <= wb_dat_i[1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   wire [WORD_W-1:0] sel_latch = latch_mem[last_sel];

   property p_load;
      (ce && load_rise) |=> (last_sel == $past(word_sync[CTRL_W-1:0]))
                            && (sel_latch == $past(word_sync));
   endproperty
   a_load: assert property (p_load) // R03
      else $error("latch not loaded on strobe rise");

   property p_no_load;
      (ce && !load_rise) |=> $stable(load_count);
   endproperty
   a_no_load: assert property (p_no_load) // R03
      else $error("latch loaded without strobe rise");

   property p_swap;
      (ce && !sense_lvl && raw_up && !pfd_hold) |=> pump_dn && !pump_up;
   endproperty
   a_swap: assert property (p_swap) // R05
      else $error("pump polarity not reversed");

   property p_normal;
      (ce && sense_lvl && raw_up && !pfd_hold) |=> pump_up && !pump_dn;
   endproperty
   a_normal: assert property (p_normal) // R05
      else $error("pump polarity wrong in normal sense");

   property p_bypass;
      bypass_switch_oe == (strobe_lvl && pump_oe);
   endproperty
   a_bypass: assert property (p_bypass) // R06
      else $error("bypass switch state wrong");

   property p_sleep_req;
      (ce && !wake_lvl && pwr_state == PWR_RUN) |=> pwr_state != PWR_RUN;
   endproperty
   a_sleep_req: assert property (p_sleep_req) // R07
      else $error("sleep request ignored");

   property p_wake;
      (ce && wake_lvl) |=> !power_down;
   endproperty
   a_wake: assert property (p_wake) // R07
      else $error("stayed powered down while awake");

   property p_gated;
      $rose(power_down) |-> !$past(pump_oe) && !$past(raw_up)
                            && !$past(raw_dn);
   endproperty
   a_gated: assert property (p_gated) // R08
      else $error("powered down with pump active");

   property p_lock;
      (ce && pump_oe) |=> !lock_indicator;
   endproperty
   a_lock: assert property (p_lock) // R09
      else $error("lock output high during pump pulse");

   property p_ratio;
      prescaler_modulus == (ctrl[CTRL_PRESC_HI] ?
         (HIGH_VARIANT ? PRESC_64 : PRESC_128) :
         (HIGH_VARIANT ? PRESC_32 : PRESC_64));
   endproperty
   a_ratio: assert property (p_ratio) // R10
      else $error("prescaler ratio wrong");

   property p_monitor;
      ce |=> compare_monitor_out ==
             ($past(ctrl[CTRL_MON_SEL]) ? $past(var_div_in)
                                        : $past(ref_div_in));
   endproperty
   a_monitor: assert property (p_monitor) // R11
      else $error("monitor output wrong");

   property p_ack;
      (wb_cyc_i && wb_stb_i && !wb_ack_o && ce) |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus ack timing wrong");

   c_load:  cover property (ce && load_rise);
   c_sleep: cover property ($rose(power_down));
   c_swap:  cover property (!sense_lvl && pump_dn);
   c_bypass: cover property (bypass_switch_oe);
endmodule

// File: include/synth_pkg.sv
/*
 * Shared constants for the synthesizer serial load and control block:
 * register offsets, field positions, reset values, prescaler ratios and
 * the power state type. Assumes nothing of its surroundings.
 */
package synth_pkg;

   // ------------------------------------------------------------------
   // Register map (byte offsets on the 32-bit bus)
   // ------------------------------------------------------------------
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_STATUS    = 8'h04;
   localparam logic [7:0]  OFF_LOADCNT   = 8'h08;
   localparam logic [7:0]  OFF_LATCH0    = 8'h10;

   // Control register fields and reset value
   localparam int          CTRL_PRESC_HI = 0;
   localparam int          CTRL_MON_SEL  = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h0;

   // Status register fields
   localparam int          ST_LOCK       = 0;
   localparam int          ST_PWRDN      = 1;
   localparam int          ST_SENSE      = 2;
   localparam int          ST_STROBE     = 3;
   localparam int          ST_PUMP_ON    = 4;
   localparam int          ST_DRAINING   = 5;
   localparam int          ST_RATIO_LSB  = 8;

   // ------------------------------------------------------------------
   // Prescaler moduli (low value P of the P/P+1 pair)
   // ------------------------------------------------------------------
   localparam logic [7:0]  PRESC_32      = 8'h20;
   localparam logic [7:0]  PRESC_64      = 8'h40;
   localparam logic [7:0]  PRESC_128     = 8'h80;

   // Defaults and reset values
   localparam int          WORD_W_DEF    = 18;
   localparam int          CTRL_W_DEF    = 1;
   localparam int          ADR_W_DEF     = 8;
   localparam logic [2:0]  PIN_RESET     = 3'h7;  // Pull-ups idle high
   localparam logic [15:0] LOADCNT_RESET = 16'h0000;

   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_DRAIN,
      PWR_SLEEP
   } power_state_t;

endpackage

// File: verif/serial_host_model.sv
/*
 * Host side of the three-wire serial load link: serial clock, data and
 * load strobe. Assumes the bench calls send_word from one process only.
 */
`timescale 1ns/10ps
module serial_host_model #(
   parameter int W = 18
) (
   // Link pins
   output logic sclk,
   output logic sdata,
   output logic load_strobe
);
   localparam realtime HALF = 62.5;

   // Serial clock stands still low outside frames
   initial begin
      sclk        = 1'b0;
      sdata       = 1'b0;
      load_strobe = 1'b0;
   end

   // One word, msb first, then a strobe with the clock held low
   task automatic send_word(input logic [W-1:0] w);
      #3.3;
      for (int i = W - 1; i >= 0; i--) begin
         sdata = w[i];
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
      #HALF load_strobe = 1'b1;
      #250 load_strobe = 1'b0;
      sdata = ~sdata;  // Released line shows no stale bit
      #HALF;
   endtask
endmodule

// File: verif/synth_serial_load_control_tb.sv
/*
 * Self-checking bench for the serial load and control block: Wishbone
 * master tasks, comparator pulses, sleep pin and a host link model.
 * Assumes the default word width and the low-frequency prescaler pair.
 */
`timescale 1ns/10ps
module synth_serial_load_control_tb;
   import synth_pkg::*;
   localparam int W     = WORD_W_DEF;
   localparam int LIMIT = 30000;
   logic          clk, rst, ce, sclk, sdata, load_strobe;
   logic          phase_sense_select, sleep_request_n;
   logic          ref_div_in, var_div_in, pump_out, pump_oe;
   logic          bypass_switch_out, bypass_switch_oe, lock_indicator;
   logic          compare_monitor_out, power_down, load_pulse;
   logic [7:0]    prescaler_modulus, wb_adr_i;
   logic [2*W-1:0] latch_data;
   logic          wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]    wb_sel_i;
   logic [31:0]   wb_dat_i, wb_dat_o, rd;
   int            failures = 0, num_checks = 0, cycles = 0;
   int            pulses = 0, loads = 0;

   synth_serial_load_control DUT (.clk(clk), .rst(rst), .ce(ce),
      .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
      .phase_sense_select(phase_sense_select),
      .sleep_request_n(sleep_request_n), .ref_div_in(ref_div_in),
      .var_div_in(var_div_in), .pump_out(pump_out), .pump_oe(pump_oe),
      .bypass_switch_out(bypass_switch_out),
      .bypass_switch_oe(bypass_switch_oe),
      .lock_indicator(lock_indicator),
      .compare_monitor_out(compare_monitor_out),
      .power_down(power_down), .prescaler_modulus(prescaler_modulus),
      .latch_data(latch_data), .load_pulse(load_pulse),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

   serial_host_model #(.W(W)) host (.sclk(sclk), .sdata(sdata),
      .load_strobe(load_strobe));

   // Clock, load pulse count and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (load_pulse === 1'b1)
         pulses++;
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Classic single cycle; holds everything until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= 4'hf;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // Ends on ack; if ack never comes, only the bench's cycle limit ends this wait
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // Rising edge on one comparator input
   task automatic edge_pulse(input bit is_var);
      @(posedge clk);
      if (is_var)
         var_div_in <= 1'b1;
      else
         ref_div_in <= 1'b1;
      repeat (3) @(posedge clk);
      ref_div_in <= 1'b0;
      var_div_in <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // Load one word and watch the switch while the strobe is high
   task automatic load_check(input logic [W-1:0] wv, input logic on);
      fork
         host.send_word(wv);
         begin
            wait (load_strobe === 1'b1);
            repeat (4) @(posedge clk);
            chk("bypass_oe", 32'(bypass_switch_oe), 32'(on));
            chk("bypass_out", 32'(bypass_switch_out),
                32'(on & phase_sense_select));
         end
      join
      repeat (4) @(posedge clk);
      loads++;
      chk("bypass_idle", 32'(bypass_switch_oe), 32'h0);
      chk("latch", 32'(latch_data[wv[0]*W +: W]), 32'(wv));
      wb(1'b0, OFF_LATCH0 + 8'(4 * wv[0]), 32'h0, rd);
      chk("latch_reg", rd, 32'(wv));
      wb(1'b0, OFF_LOADCNT, 32'h0, rd);
      chk("loadcnt", rd, 32'(loads));
      chk("pulses", 32'(pulses), 32'(loads));
   endtask

   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      phase_sense_select = 1'b1;
      sleep_request_n = 1'b1;
      ref_div_in = 1'b0;
      var_div_in = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      void'($urandom(32'h9d56));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk("modulus", 32'(prescaler_modulus), 32'(PRESC_64));
      chk("latch_rst", 32'(latch_data != '0), 32'h0);
      chk("lock_idle", 32'(lock_indicator), 32'h1);
      chk("pd_run", 32'(power_down), 32'h0);
      wb(1'b0, OFF_CTRL, 32'h0, rd);
      chk("ctrl_rst", rd, 32'(CTRL_RESET));
      // High ratio selected and reported
      wb(1'b1, OFF_CTRL, 32'h1, rd);
      wb(1'b0, OFF_STATUS, 32'h0, rd);
      chk("status_ratio", 32'(rd[15:8]), 32'(PRESC_128));
      chk("modulus_hi", 32'(prescaler_modulus), 32'(PRESC_128));
      // Monitor follows the selected comparator input
      for (int m = 0; m < 2; m++) begin
         wb(1'b1, OFF_CTRL, {30'h0, m[0], 1'b0}, rd);
         ref_div_in <= 1'b1;
         repeat (4) @(posedge clk);
         chk("mon_ref", 32'(compare_monitor_out), 32'(m == 0));
         ref_div_in <= 1'b0;
         var_div_in <= 1'b1;
         repeat (4) @(posedge clk);
         chk("mon_var", 32'(compare_monitor_out), 32'(m == 1));
         var_div_in <= 1'b0;
         repeat (4) @(posedge clk);
      end
      chk("modulus_lo", 32'(prescaler_modulus), 32'(PRESC_64));
      // Both senses, with a load while the pump drives
      for (int s = 0; s < 2; s++) begin
         phase_sense_select <= s[0];
         repeat (4) @(posedge clk);
         edge_pulse(1'b0);
         chk("pump_on", 32'(pump_oe), 32'h1);
         chk("pump_dir", 32'(pump_out), 32'(s));
         load_check(W'($urandom), 1'b1);
         edge_pulse(1'b1);
         chk("pump_off", 32'(pump_oe), 32'h0);
      end
      // Corner words, then random ones
      load_check('1, 1'b0);
      load_check('0, 1'b0);
      for (int k = 0; k < 6; k++)
         load_check(W'($urandom), 1'b0);
      // Low enable freezes the comparator, high lets the edge through
      ce <= 1'b0;
      ref_div_in <= 1'b1;
      repeat (4) @(posedge clk);
      chk("ce_hold", 32'(pump_oe), 32'h0);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      chk("ce_run", 32'(pump_oe), 32'h1);
      edge_pulse(1'b1);
      // Sleep waits for the pump to go idle
      edge_pulse(1'b0);
      sleep_request_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk("pd_wait", 32'(power_down), 32'h0);
      edge_pulse(1'b1);
      repeat (6) @(posedge clk);
      chk("pd_sleep", 32'(power_down), 32'h1);
      chk("lock_sleep", 32'(lock_indicator), 32'h0);
      wb(1'b0, OFF_STATUS, 32'h0, rd);
      chk("status_pd", 32'(rd[ST_PWRDN]), 32'h1);
      sleep_request_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk("pd_wake", 32'(power_down), 32'h0);
      wb(1'b0, 8'hfc, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      test_done();
   end
endmodule
